// ===== verilog/dncsw_pkg.sv
// Contract
// - Status word is shared by all sources and rejects every write.
// - Status bit 1 shows a run command is present.
// - Status bit 2 follows the emergency run override state.
// - Status bit 5 shows which ramp pair is in use.
// - Status bit 6 flags incompatible settings; drive cannot be enabled then.
// - Status bit 7 shows alarm, bit 15 shows a registered fault.
// - Status bit 8 shows running, bit 9 shows enabled and ready.
// - Status bit 10 is actual direction, 1 forward.
// - Status bits 11, 12, 13: inching, remote, undervoltage.
// - Speed feedback is signed 16-bit, 8192 equals rated frequency.
// - Feedback scale reaches 32767, four times rated frequency.
// - Feedback is negative while the motor turns in reverse.
// - Control word is written only from the network; others read it.
// - Control bit 0 ramps up to reference, or ramps down to stop.
// - Control bit 1 enables the drive; clear removes motor power.
// - Control bit 2 runs with the reference direction, clear reverses it.
// - Control bit 3 enables inching; bit 4 selects remote control.
// - Control bit 5 selects the second ramp pair.
// - Control bit 7 resets a present fault; clear does nothing.
// - Speed reference is written only from communication interfaces.
// - Network reference applies only when network is the reference source.
// - Direction is forward when reference sign agrees with control bit 2.
// - Network speed values saturate at 32767 and -32768.
package dncsw_pkg;
  localparam int unsigned WORD_W = 16;
  // Register selectors of the word bank.
  localparam logic [1:0] SEL_STATUS = 2'h0;
  localparam logic [1:0] SEL_FEEDBACK = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_SPEEDREF = 2'h3;
  // Access source codes.
  localparam logic [1:0] SRC_NETWORK = 2'h0;
  localparam logic [1:0] SRC_KEYPAD = 2'h1;
  localparam logic [1:0] SRC_LOGIC = 2'h2;
  // Control word bit positions.
  localparam int unsigned CB_RAMP = 0;
  localparam int unsigned CB_GEN = 1;
  localparam int unsigned CB_FWD = 2;
  localparam int unsigned CB_INCH = 3;
  localparam int unsigned CB_REMOTE = 4;
  localparam int unsigned CB_RAMP2 = 5;
  localparam int unsigned CB_FRESET = 7;
  // Status word bit positions.
  localparam int unsigned SB_RUN = 1;
  localparam int unsigned SB_OVERRIDE = 2;
  localparam int unsigned SB_RAMP2 = 5;
  localparam int unsigned SB_CONFIG = 6;
  localparam int unsigned SB_ALARM = 7;
  localparam int unsigned SB_RUNNING = 8;
  localparam int unsigned SB_ENABLED = 9;
  localparam int unsigned SB_FWD = 10;
  localparam int unsigned SB_INCH = 11;
  localparam int unsigned SB_REMOTE = 12;
  localparam int unsigned SB_UNDERV = 13;
  localparam int unsigned SB_FAULT = 15;
  localparam logic [15:0] CTRL_MASK = 16'h00BF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SREF_RESET = 16'h0000;
  // Speed scale limits.
  localparam logic signed [15:0] SPD_RATED = 16'sh2000;
  localparam logic signed [17:0] SPD_MAX = 18'sh07FFF;
  localparam logic signed [17:0] SPD_MIN = -18'sh08000;

  // Drive state inputs that feed the status word.
  typedef struct packed {
    logic run_cmd;
    logic override_on;
    logic ramp2_used;
    logic config_bad;
    logic alarm;
    logic running;
    logic enabled;
    logic forward;
    logic inching;
    logic remote;
    logic undervolt;
    logic fault;
  } dncsw_state_t;

  // Decoded commands sent to the drive core.
  typedef struct packed {
    logic ramp_run;
    logic gen_enable;
    logic dir_forward;
    logic inching_en;
    logic remote_sel;
    logic ramp2_sel;
    logic fault_reset;
  } dncsw_cmd_t;
endpackage : dncsw_pkg

// ===== verilog/dncsw_sat16.sv
`timescale 1ns/1ps
// Clamps a wide signed value into the signed 16-bit network range.
module dncsw_sat16 (
  input wire logic signed [17:0] val_in, // Wide signed value.
  output logic signed [15:0] val_out // Saturated value.
);
  // Saturate rather than wrap so huge speeds never flip sign.
  always_comb begin
    if (val_in > dncsw_pkg::SPD_MAX) begin
      val_out = dncsw_pkg::SPD_MAX[15:0];
    end else if (val_in < dncsw_pkg::SPD_MIN) begin
      val_out = dncsw_pkg::SPD_MIN[15:0];
    end else begin
      val_out = val_in[15:0];
    end
  end
endmodule : dncsw_sat16

// ===== verilog/dncsw_dir.sv
`timescale 1ns/1ps
// Commanded direction from reference sign and direction bit.
module dncsw_dir (
  input wire logic signed [15:0] ref_in, // Speed reference.
  input wire logic fwd_bit, // Control direction bit.
  output logic dir_fwd // 1 when forward commanded.
);
  // Sign agreeing with the bit means forward; zero counts as positive.
  assign dir_fwd = (ref_in[15] == 1'b0) ? fwd_bit : ~fwd_bit;
endmodule : dncsw_dir

// ===== verilog/dncsw_bank.sv
`timescale 1ns/1ps
// Network control and status word bank of the drive.
module dncsw_bank (
  input wire logic clk, // 10 MHz clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic ce, // Clock enable; state freezes while low.
  input wire logic wr_en, // Write strobe, one cycle.
  input wire logic [1:0] wr_src, // Source of the write.
  input wire logic [1:0] wr_sel, // Word selected for write.
  input wire logic [15:0] wr_data, // Write data.
  input wire logic [1:0] rd_sel, // Word selected for read.
  output logic [15:0] rd_data, // Registered read data.
  output logic wr_err, // Pulse: write was refused.
  input wire dncsw_pkg::dncsw_state_t st_in, // Asynchronous drive state.
  input wire logic signed [17:0] speed_meas, // Measured speed, wide signed.
  input wire logic net_ref_sel, // Network chosen as reference source.
  input wire logic signed [15:0] alt_ref, // Reference from other sources.
  output dncsw_pkg::dncsw_cmd_t cmd, // Commands to drive core.
  output logic signed [15:0] speed_ref_out, // Applied speed reference.
  output logic dir_cmd_fwd // Commanded direction, 1 forward.
);
  // Drive state arrives from other logic domains; two-stage synchroniser.
  dncsw_pkg::dncsw_state_t st_m_q, st_m_d, st_s_q, st_s_d;
  logic net_sel_m_q, net_sel_m_d, net_sel_s_q, net_sel_s_d;

  always_comb begin
    st_m_d = st_in;
    st_s_d = st_m_q;
    net_sel_m_d = net_ref_sel;
    net_sel_s_d = net_sel_m_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_m_q <= '0;
      st_s_q <= '0;
      net_sel_m_q <= 1'b0;
      net_sel_s_q <= 1'b0;
    end else if (ce) begin
      st_m_q <= st_m_d;
      st_s_q <= st_s_d;
      net_sel_m_q <= net_sel_m_d;
      net_sel_s_q <= net_sel_s_d;
    end
  end

  // Writable words. Only the network may change them; other sources are refused.
  logic [15:0] ctrl_q, ctrl_d;
  logic signed [15:0] sref_q, sref_d;
  logic err_q, err_d;
  logic net_wr;

  assign net_wr = wr_en && (wr_src == dncsw_pkg::SRC_NETWORK);

  always_comb begin
    ctrl_d = ctrl_q;
    sref_d = sref_q;
    err_d = 1'b0;
    if (wr_en) begin
      unique case (wr_sel)
        dncsw_pkg::SEL_STATUS, dncsw_pkg::SEL_FEEDBACK: begin
          err_d = 1'b1;
        end
        dncsw_pkg::SEL_CONTROL: begin
          if (net_wr) begin
            ctrl_d = wr_data & dncsw_pkg::CTRL_MASK;
          end else begin
            err_d = 1'b1;
          end
        end
        dncsw_pkg::SEL_SPEEDREF: begin
          if (net_wr) begin
            sref_d = wr_data;
          end else begin
            err_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= dncsw_pkg::CTRL_RESET;
      sref_q <= dncsw_pkg::SREF_RESET;
      err_q <= 1'b0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      sref_q <= sref_d;
      err_q <= err_d;
    end
  end

  assign wr_err = err_q;

  // Status word assembly; reserved bits 0, 3, 4 and 14 are zero.
  logic [15:0] status_w;
  always_comb begin
    status_w = '0;
    status_w[dncsw_pkg::SB_RUN] = st_s_q.run_cmd;
    status_w[dncsw_pkg::SB_OVERRIDE] = st_s_q.override_on;
    status_w[dncsw_pkg::SB_RAMP2] = st_s_q.ramp2_used;
    status_w[dncsw_pkg::SB_CONFIG] = st_s_q.config_bad;
    status_w[dncsw_pkg::SB_ALARM] = st_s_q.alarm;
    status_w[dncsw_pkg::SB_RUNNING] = st_s_q.running;
    status_w[dncsw_pkg::SB_ENABLED] = st_s_q.enabled && !st_s_q.config_bad;
    status_w[dncsw_pkg::SB_FWD] = st_s_q.forward;
    status_w[dncsw_pkg::SB_INCH] = st_s_q.inching;
    status_w[dncsw_pkg::SB_REMOTE] = st_s_q.remote;
    status_w[dncsw_pkg::SB_UNDERV] = st_s_q.undervolt;
    status_w[dncsw_pkg::SB_FAULT] = st_s_q.fault;
  end

  // Feedback sign follows actual direction so reverse reads negative at any nonzero speed.
  // The sign goes on before saturation so a fast reverse reaches the negative limit.
  logic signed [18:0] fb_abs;
  logic signed [17:0] fb_lim, fb_pre;
  always_comb begin
    fb_abs = speed_meas[17] ? -19'(speed_meas) : 19'(speed_meas);
    fb_lim = (fb_abs > 19'(-dncsw_pkg::SPD_MIN)) ? -dncsw_pkg::SPD_MIN : fb_abs[17:0];
    fb_pre = st_s_q.forward ? fb_lim : -fb_lim;
  end

  // Signed speed is saturated into the 16-bit scale word.
  logic signed [15:0] fb_word;
  dncsw_sat16 u_fb_sat (
    .val_in(fb_pre),
    .val_out(fb_word)
  );

  // Registered read port serves every source with the same words.
  logic [15:0] rd_q, rd_d;
  always_comb begin
    rd_d = '0;
    unique case (rd_sel)
      dncsw_pkg::SEL_STATUS: rd_d = status_w;
      dncsw_pkg::SEL_FEEDBACK: rd_d = fb_word;
      dncsw_pkg::SEL_CONTROL: rd_d = ctrl_q;
      dncsw_pkg::SEL_SPEEDREF: rd_d = sref_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_q <= '0;
    end else if (ce) begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;

  // Reference selection: network value only when network is the source.
  logic signed [15:0] ref_sel;
  logic signed [17:0] ref_wide;
  always_comb begin
    ref_sel = net_sel_s_q ? sref_q : alt_ref;
    ref_wide = {{2{ref_sel[15]}}, ref_sel};
  end

  logic signed [15:0] ref_clamped;
  dncsw_sat16 u_ref_sat (
    .val_in(ref_wide),
    .val_out(ref_clamped)
  );

  logic dir_fwd;
  dncsw_dir u_dir (
    .ref_in(ref_clamped),
    .fwd_bit(ctrl_q[dncsw_pkg::CB_FWD]),
    .dir_fwd(dir_fwd)
  );

  // Command outputs are registered from the control word.
  dncsw_pkg::dncsw_cmd_t cmd_q, cmd_d;
  logic signed [15:0] sro_q, sro_d;
  logic dir_q, dir_d;
  always_comb begin
    cmd_d.ramp_run = ctrl_q[dncsw_pkg::CB_RAMP];
    // Config conflict blocks enabling regardless of the network bit.
    cmd_d.gen_enable = ctrl_q[dncsw_pkg::CB_GEN] && !st_s_q.config_bad;
    cmd_d.dir_forward = dir_fwd;
    cmd_d.inching_en = ctrl_q[dncsw_pkg::CB_INCH];
    cmd_d.remote_sel = ctrl_q[dncsw_pkg::CB_REMOTE];
    cmd_d.ramp2_sel = ctrl_q[dncsw_pkg::CB_RAMP2];
    cmd_d.fault_reset = ctrl_q[dncsw_pkg::CB_FRESET] && st_s_q.fault;
    sro_d = ref_clamped;
    dir_d = dir_fwd;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_q <= '0;
      sro_q <= '0;
      dir_q <= 1'b0;
    end else if (ce) begin
      cmd_q <= cmd_d;
      sro_q <= sro_d;
      dir_q <= dir_d;
    end
  end

  assign cmd = cmd_q;
  assign speed_ref_out = sro_q;
  assign dir_cmd_fwd = dir_q;
endmodule : dncsw_bank

// ===== tb/dncsw_bank_asserts.sv
`timescale 1ns/1ps
// Port checker for the word bank; refusals and reserved bits matter most.
module dncsw_bank_asserts (
  input wire logic clk, // Clock.
  input wire logic rstn, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic wr_en, // Write strobe.
  input wire logic [1:0] wr_src, // Write source.
  input wire logic [1:0] wr_sel, // Write word.
  input wire logic [1:0] rd_sel, // Read word.
  input wire logic [15:0] rd_data, // Read data.
  input wire logic wr_err, // Refusal pulse.
  input wire dncsw_pkg::dncsw_state_t st_in, // Drive state.
  input wire dncsw_pkg::dncsw_cmd_t cmd // Commands.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // A write only counts while the clock enable is high.
  wire wr_go = ce && wr_en;
  wire from_net = wr_src == 2'h0;
  // Status lasts four cycles so the two synchroniser flops have settled.
  chk_status_ro: assert property (wr_go && wr_sel == 2'h0 |=> wr_err)
    else $error("status write not refused");
  chk_ctrl_src: assert property (wr_go && wr_sel == 2'h2 && !from_net |=> wr_err)
    else $error("control write from other source not refused");
  chk_sref_src: assert property (wr_go && wr_sel == 2'h3 && !from_net |=> wr_err)
    else $error("reference write from other source not refused");
  chk_net_taken: assert property (wr_go && wr_sel[1] && from_net |=> !wr_err)
    else $error("network write refused");
  chk_ctrl_rsvd: assert property (ce && rd_sel == 2'h2 |=> (rd_data & 16'hFF40) == 16'h0000)
    else $error("control reserved bits not zero");
  chk_stat_rsvd: assert property (ce && rd_sel == 2'h0 |=> (rd_data & 16'h4019) == 16'h0000)
    else $error("status reserved bits not zero");
  chk_cfg_block: assert property ((ce && st_in.config_bad) [*4] |=> !cmd.gen_enable)
    else $error("drive enabled with bad settings");
  chk_no_freset: assert property ((ce && !st_in.fault) [*4] |=> !cmd.fault_reset)
    else $error("fault reset without fault");
endmodule : dncsw_bank_asserts

bind dncsw_bank dncsw_bank_asserts u_chk (.clk(clk), .rstn(rstn), .ce(ce), .wr_en(wr_en),
  .wr_src(wr_src), .wr_sel(wr_sel), .rd_sel(rd_sel), .rd_data(rd_data), .wr_err(wr_err),
  .st_in(st_in), .cmd(cmd));

// ===== tb/dncsw_master.sv
`timescale 1ns/1ps
// Network master model: whole-word writes with a one-cycle strobe.
module dncsw_master (
  input wire logic clk, // Clock.
  output logic wr_en, // Write strobe.
  output logic [1:0] wr_src, // Source code.
  output logic [1:0] wr_sel, // Word code.
  output logic [15:0] wr_data // Write data.
);
  // Idle at time zero.
  initial begin
    wr_en = 1'b0;
    wr_src = 2'h0;
    wr_sel = 2'h0;
    wr_data = 16'h0000;
  end
  // The reference goes out as a signed word, 8192 standing for rated speed.
  task automatic put(input logic [1:0] src, input logic [1:0] sel, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_src <= src;
    wr_sel <= sel;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_data <= ~d; // Released data shows junk, not the last value.
  endtask : put
endmodule : dncsw_master

// ===== tb/test_drive_network_control_status_words.sv
`timescale 1ns/1ps
// Random and corner stimulus for the word bank, checked against bench models.
module test_drive_network_control_status_words;
  logic clk, rstn, ce, wr_en, net_ref_sel, wr_err, dir_cmd_fwd;
  logic [1:0] wr_src, wr_sel, rd_sel, src, sel;
  logic [15:0] wr_data, rd_data, ctrl, sref, d, rsel;
  logic signed [15:0] alt_ref, speed_ref_out;
  logic signed [17:0] speed_meas;
  logic signed [17:0] spd [4] = '{18'sh02000, 18'sh09C40, -18'sh00800, 18'sh00000};
  dncsw_pkg::dncsw_state_t st_in;
  dncsw_pkg::dncsw_cmd_t cmd;
  int errors, checks_done, seed, i;
  dncsw_master u_master (.clk(clk), .wr_en(wr_en), .wr_src(wr_src), .wr_sel(wr_sel),
    .wr_data(wr_data));
  dncsw_bank u_dut (.clk(clk), .rstn(rstn), .ce(ce), .wr_en(wr_en), .wr_src(wr_src),
    .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data), .wr_err(wr_err),
    .st_in(st_in), .speed_meas(speed_meas), .net_ref_sel(net_ref_sel), .alt_ref(alt_ref),
    .cmd(cmd), .speed_ref_out(speed_ref_out), .dir_cmd_fwd(dir_cmd_fwd));
  // Bench models of the status word, the feedback scale and the commands.
  function automatic logic [15:0] f_stat(dncsw_pkg::dncsw_state_t s);
    f_stat = {s.fault, 1'b0, s.undervolt, s.remote, s.inching, s.forward,
      s.enabled & ~s.config_bad, s.running, s.alarm, s.config_bad, s.ramp2_used, 2'b00,
      s.override_on, s.run_cmd, 1'b0};
  endfunction : f_stat
  function automatic logic [15:0] f_fb(logic signed [17:0] m, logic fwd);
    logic signed [18:0] x;
    x = m;
    if (x < 0) x = -x;
    if (!fwd) x = -x;
    if (x > 32767) x = 32767;
    if (x < -32768) x = -32768;
    f_fb = x[15:0];
  endfunction : f_fb
  // Commanded direction: forward when the reference sign agrees with control bit 2.
  function automatic logic [6:0] f_cmd(logic [15:0] c, dncsw_pkg::dncsw_state_t s,
    logic [15:0] r);
    f_cmd = {c[0], c[1] & ~s.config_bad, (~r[15] == c[2]), c[3], c[4], c[5], c[7] & s.fault};
  endfunction : f_cmd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Read data lands one cycle after the select; two edges leave margin.
  task automatic rdchk(input logic [1:0] s, input logic [15:0] exp);
    @(posedge clk);
    rd_sel <= s;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(rd_data, exp);
  endtask : rdchk
  task automatic close_out;
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The whole run is under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out();
  end
  // The first eight passes are network writes of control, then reference.
  initial begin
    seed = 99;
    rstn = 1'b0;
    ce = 1'b1;
    rd_sel = 2'h0;
    net_ref_sel = 1'b1;
    alt_ref = 16'sh0000;
    st_in = '0;
    speed_meas = 18'sh00000;
    ctrl = 16'h0000;
    sref = 16'h0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdchk(dncsw_pkg::SEL_CONTROL, ctrl);
    for (i = 0; i < 32; i++) begin
      @(posedge clk);
      st_in <= 12'($random(seed));
      speed_meas <= (i < 4) ? spd[i] : 18'($random(seed) % 40000);
      alt_ref <= 16'($random(seed));
      net_ref_sel <= 1'($random(seed));
      src = (i < 8) ? 2'h0 : 2'($random(seed));
      sel = (i < 8) ? {1'b1, i[2]} : 2'($random(seed));
      d = 16'($random(seed));
      u_master.put(src, sel, d);
      if (src == 2'h0 && sel == 2'h2) ctrl = d & dncsw_pkg::CTRL_MASK;
      if (src == 2'h0 && sel == 2'h3) sref = d;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rsel = net_ref_sel ? sref : alt_ref;
      chk(16'(cmd), 16'(f_cmd(ctrl, st_in, rsel)));
      chk(speed_ref_out, rsel);
      chk(16'(dir_cmd_fwd), 16'(~rsel[15] == ctrl[2]));
      rdchk(dncsw_pkg::SEL_STATUS, f_stat(st_in));
      rdchk(dncsw_pkg::SEL_FEEDBACK, f_fb(speed_meas, st_in.forward));
      rdchk(dncsw_pkg::SEL_CONTROL, ctrl);
      rdchk(dncsw_pkg::SEL_SPEEDREF, sref);
    end
    // With the clock enable low a network write must not land.
    @(posedge clk);
    ce <= 1'b0;
    u_master.put(2'h0, dncsw_pkg::SEL_CONTROL, ~ctrl);
    @(posedge clk);
    ce <= 1'b1;
    rdchk(dncsw_pkg::SEL_CONTROL, ctrl);
    // A reset in mid-run returns both writable words to their reset values.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    ctrl = dncsw_pkg::CTRL_RESET;
    sref = dncsw_pkg::SREF_RESET;
    rdchk(dncsw_pkg::SEL_CONTROL, ctrl);
    rdchk(dncsw_pkg::SEL_SPEEDREF, sref);
    close_out();
  end
endmodule : test_drive_network_control_status_words
